// ===== tw_port.sv
// Purpose: serial slave port giving a host access to configuration registers
// Assumes: serial clock at most one eighth of ref_clk_i; register file on ref_clk_i
// Notes: register contents live outside, except the two port configuration bits
// Behaviour
// R1: eight instruction bits, then data phase
// R2: instruction top bit set means read
// R3: bits six and five give one to four bytes
// R4: low five bits give start address
// R5: chip select high restarts at instruction phase
// R6: unfinished byte is never written
// R7: sample on rising, launch on falling edge
// R8: both data outputs released while deselected
// R9: host holds chip select low whole cycle
// R10: config bit seven selects bidirectional data pin
// R11: bidirectional mode keeps separate output released
// R12: config bit six selects least-significant-first order
// R13: msb-first order decrements byte address
// R14: lsb-first order increments byte address
// R15: each write byte lands at its last bit
// R16: new port settings apply to following bytes
// R17: host changes port settings with single bytes
// R18: read shifts out addressed byte from first fall
module tw_port
	import tw_pkg::*;
#(
	parameter int ADDR_W = 5
)
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	// serial link pins
	input wire logic sclk_i,
	input wire logic chip_select_n_i,
	input wire logic sdio_i,
	output logic sdio_o,
	output logic sdio_oe_n_o,
	output logic serial_data_out_o,
	output logic serial_data_out_oe_n_o,
	// register file side
	output logic [ADDR_W-1:0] reg_rd_addr_o,
	input wire logic [TW_BYTE_W-1:0] reg_rdata_i,
	output logic reg_wr_o,
	output logic [ADDR_W-1:0] reg_wr_addr_o,
	output logic [TW_BYTE_W-1:0] reg_wdata_o,
	// port configuration state
	output logic bidir_mode_o,
	output logic lsb_first_o
);
	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	if (ADDR_W != TW_ADDR_W)
	begin : g_chk
		$error("ADDR_W must match the five-bit instruction address");
	end

	// ----------------------------------------------------------------
	// reset release and pin sampling
	// ----------------------------------------------------------------
	logic [1:0] rst_sync;
	logic rst_n;

	// assert at once, release after two edges
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			rst_sync <= 2'h0;
		end
		else
		begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	tw_pins_if pins ();

	tw_sync u_sync (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n),
		.sclk_i(sclk_i),
		.cs_n_i(chip_select_n_i),
		.sdi_i(sdio_i),
		.pins(pins)
	);

	// ----------------------------------------------------------------
	// port state
	// ----------------------------------------------------------------
	typedef struct packed {
		tw_state_t state;
		logic [2:0] bit_cnt;
		logic [TW_BYTE_W-1:0] shreg;
		logic rd;
		logic [1:0] bytes_left;
		logic [TW_ADDR_W-1:0] addr;
		logic cfg_bidir;
		logic cfg_lsb;
		logic drive;
		logic out_bit;
		logic wr;
		logic [TW_ADDR_W-1:0] waddr;
		logic [TW_BYTE_W-1:0] wdata;
	} tw_core_t;

	tw_core_t st;
	tw_core_t next_st;
	logic [TW_BYTE_W-1:0] shift_in;
	logic [TW_BYTE_W-1:0] rd_byte;
	logic [2:0] bit_idx;
	logic byte_done;

	// R12: bit order for both instruction and data
	always_comb
	begin
		if (st.cfg_lsb)
		begin
			shift_in = {pins.sdi, st.shreg[TW_BYTE_W-1:1]};
			bit_idx = st.bit_cnt;
		end
		else
		begin
			shift_in = {st.shreg[TW_BYTE_W-2:0], pins.sdi};
			bit_idx = TW_LAST_BIT - st.bit_cnt;
		end
	end

	// config bits are held here, so reads of address zero merge them in
	assign rd_byte = (st.addr == TW_CFG_ADDR) ?
		{st.cfg_bidir, st.cfg_lsb, reg_rdata_i[TW_CFG_LSB_BIT-1:0]} : reg_rdata_i;
	assign byte_done = pins.sclk_rise && (st.bit_cnt == TW_LAST_BIT);

	// sequencing of instruction and data phases
	always_comb
	begin
		next_st = st;
		next_st.wr = 1'b0;
		if (pins.cs_n)
		begin
			// R5: deselect always returns to the start
			next_st.state = ST_IDLE;
			// R8: release both data outputs
			next_st.drive = 1'b0;
		end
		else
		begin
			case (st.state)
				ST_IDLE:
				begin
					next_st.state = ST_INSTR;
					next_st.bit_cnt = TW_FIRST_BIT;
				end
				ST_INSTR:
				begin
					// R1: first eight rising edges form the instruction
					if (pins.sclk_rise)
					begin
						next_st.shreg = shift_in;
						next_st.bit_cnt = st.bit_cnt + 3'h1;
						if (byte_done)
						begin
							next_st.state = ST_DATA;
							// R2: direction flag
							next_st.rd = shift_in[TW_RW_BIT];
							// R3: byte count decode
							next_st.bytes_left = shift_in[TW_CNT_HI:TW_CNT_LO];
							// R4: start address
							next_st.addr = shift_in[TW_ADDR_HI:0];
						end
					end
				end
				ST_DATA:
				begin
					// R7: launch read bits on falling edges
					// R18: current contents of addressed byte
					if (pins.sclk_fall && st.rd)
					begin
						next_st.drive = 1'b1;
						next_st.out_bit = rd_byte[bit_idx];
					end
					// R7: sample on rising edges
					if (pins.sclk_rise)
					begin
						next_st.shreg = shift_in;
						next_st.bit_cnt = st.bit_cnt + 3'h1;
					end
					if (byte_done)
					begin
						// R15: write lands at the byte's last bit
						if (!st.rd)
						begin
							next_st.wr = 1'b1;
							next_st.waddr = st.addr;
							next_st.wdata = shift_in;
							// R16: new settings govern the following bytes
							if (st.addr == TW_CFG_ADDR)
							begin
								next_st.cfg_bidir = shift_in[TW_CFG_BIDIR_BIT];
								next_st.cfg_lsb = shift_in[TW_CFG_LSB_BIT];
							end
						end
						// R13: decrement in msb-first order
						// R14: increment in lsb-first order
						if (next_st.cfg_lsb)
						begin
							next_st.addr = st.addr + TW_ADDR_STEP;
						end
						else
						begin
							next_st.addr = st.addr - TW_ADDR_STEP;
						end
						if (st.bytes_left == 2'h0)
						begin
							next_st.state = ST_DONE;
						end
						else
						begin
							next_st.bytes_left = st.bytes_left - 2'h1;
						end
					end
				end
				ST_DONE:
				begin
					// extra edges ignored until the host deselects
					next_st.state = ST_DONE;
				end
				default:
				begin
					next_st.state = ST_IDLE;
				end
			endcase
		end
	end

	// R6: partial bytes never reach the write strobe
	always_ff @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st <= '{state: ST_IDLE, bit_cnt: 3'h0, shreg: 8'h00, rd: 1'b0, bytes_left: 2'h0,
				addr: 5'h00, cfg_bidir: TW_CFG_BIDIR_RST, cfg_lsb: TW_CFG_LSB_RST, drive: 1'b0,
				out_bit: 1'b0, wr: 1'b0, waddr: 5'h00, wdata: 8'h00};
		end
		else
		begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// R10: pin mode picks which output carries read data
	// R11: separate output stays released in bidirectional mode
	assign sdio_oe_n_o = ~(st.drive & st.cfg_bidir);
	assign serial_data_out_oe_n_o = ~(st.drive & ~st.cfg_bidir);
	assign sdio_o = st.out_bit;
	assign serial_data_out_o = st.out_bit;
	assign reg_rd_addr_o = st.addr;
	assign reg_wr_o = st.wr;
	assign reg_wr_addr_o = st.waddr;
	assign reg_wdata_o = st.wdata;
	assign bidir_mode_o = st.cfg_bidir;
	assign lsb_first_o = st.cfg_lsb;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n);

	AST_DESELECT_HIZ: assert property (pins.cs_n |=> sdio_oe_n_o && serial_data_out_oe_n_o) // R8
		else $error("data output driven while deselected");
	AST_BIDIR_SEP_OUT: assert property (st.cfg_bidir |-> serial_data_out_oe_n_o) // R11
		else $error("separate output driven in bidirectional mode");
	AST_NO_PARTIAL: assert property (pins.cs_n |=> !reg_wr_o) // R6
		else $error("write issued after deselect");
	AST_INSTR_END: assert property (st.state == ST_INSTR && byte_done && !pins.cs_n // R1
		|=> st.state == ST_DATA && st.bit_cnt == TW_FIRST_BIT)
		else $error("instruction phase did not end after eight bits");
	AST_READ_NO_WR: assert property (st.state == ST_DATA && st.rd |=> !reg_wr_o) // R2
		else $error("write strobe during read transfer");
	AST_COUNT: assert property (st.state == ST_INSTR && byte_done && !pins.cs_n // R3
		|=> st.bytes_left == $past(shift_in[TW_CNT_HI:TW_CNT_LO]))
		else $error("byte count decoded wrongly");
	AST_START_ADDR: assert property (st.state == ST_INSTR && byte_done && !pins.cs_n // R4
		|=> st.addr == $past(shift_in[TW_ADDR_HI:0]))
		else $error("start address decoded wrongly");
	AST_RESTART: assert property ($fell(pins.cs_n) |=> st.state == ST_INSTR && st.bit_cnt == TW_FIRST_BIT) // R5
		else $error("port did not restart on chip select");
	AST_DEC: assert property (st.state == ST_DATA && byte_done && !pins.cs_n && !next_st.cfg_lsb // R13
		|=> st.addr == $past(st.addr) - TW_ADDR_STEP)
		else $error("address did not decrement");
	AST_INC: assert property (st.state == ST_DATA && byte_done && !pins.cs_n && next_st.cfg_lsb // R14
		|=> st.addr == $past(st.addr) + TW_ADDR_STEP)
		else $error("address did not increment");
	AST_WR_AT_BIT: assert property (st.state == ST_DATA && !st.rd && byte_done && !pins.cs_n // R15
		|=> reg_wr_o && reg_wdata_o == $past(shift_in))
		else $error("write not issued at the last bit");
	AST_CFG_UPDATE: assert property (reg_wr_o && reg_wr_addr_o == TW_CFG_ADDR // R16
		|-> bidir_mode_o == reg_wdata_o[TW_CFG_BIDIR_BIT] && lsb_first_o == reg_wdata_o[TW_CFG_LSB_BIT])
		else $error("port configuration not updated");
	AST_LAUNCH_FALL: assert property ($changed(st.out_bit) |-> $past(pins.sclk_fall)) // R7
		else $error("read bit changed away from a falling edge");
endmodule

// ===== tw_pkg.sv
// Purpose: shared constants and types of the three-wire configuration port
// Assumes: five-bit register space, eight-bit registers
// Notes: port configuration bits live at address zero
package tw_pkg;
	// ----------------------------------------------------------------
	// instruction byte layout
	// ----------------------------------------------------------------
	localparam int TW_BYTE_W = 8;
	localparam int TW_ADDR_W = 5;
	localparam int TW_RW_BIT = 7;
	localparam int TW_CNT_HI = 6;
	localparam int TW_CNT_LO = 5;
	localparam int TW_ADDR_HI = 4;
	localparam logic [2:0] TW_LAST_BIT = 3'h7;
	localparam logic [2:0] TW_FIRST_BIT = 3'h0;

	// ----------------------------------------------------------------
	// port configuration register
	// ----------------------------------------------------------------
	localparam logic [4:0] TW_CFG_ADDR = 5'h00;
	localparam int TW_CFG_BIDIR_BIT = 7;
	localparam int TW_CFG_LSB_BIT = 6;
	localparam logic TW_CFG_BIDIR_RST = 1'b0;
	localparam logic TW_CFG_LSB_RST = 1'b0;
	localparam logic [4:0] TW_ADDR_STEP = 5'h01;

	// synchroniser reset: {sclk, chip select (idle high), data}
	localparam logic [2:0] TW_SYNC_RST = 3'h2;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_INSTR,
		ST_DATA,
		ST_DONE
	} tw_state_t;
endpackage

// ===== tw_pins_if.sv
// Purpose: sampled link events from the synchroniser to the port core
// Assumes: all signals on ref_clk_i
// Notes: rise and fall are one-cycle pulses
interface tw_pins_if;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_n;
	logic sdi;
	modport src (output sclk_rise, output sclk_fall, output cs_n, output sdi);
	modport dst (input sclk_rise, input sclk_fall, input cs_n, input sdi);
endinterface

// ===== tw_sync.sv
// Purpose: two-stage synchroniser and serial clock edge finder
// Assumes: serial clock well below half of ref_clk_i
// Notes: all three pins share one latency, so data stays aligned to edges
module tw_sync
	import tw_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// raw pins
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic sdi_i,
	// sampled events
	tw_pins_if.src pins
);
	typedef struct packed {
		logic [2:0] s1;
		logic [2:0] s2;
		logic sclk_d;
	} tw_sync_t;

	tw_sync_t st;
	tw_sync_t next_st;

	// first stage feeds only the second stage
	always_comb
	begin
		next_st = st;
		next_st.s1 = {sclk_i, cs_n_i, sdi_i};
		next_st.s2 = st.s1;
		next_st.sclk_d = st.s2[2];
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			st <= '{s1: TW_SYNC_RST, s2: TW_SYNC_RST, sclk_d: 1'b0};
		end
		else
		begin
			st <= next_st;
		end
	end

	// edges found on the second stage only
	assign pins.sclk_rise = st.s2[2] & ~st.sclk_d;
	assign pins.sclk_fall = ~st.s2[2] & st.sclk_d;
	assign pins.cs_n = st.s2[1];
	assign pins.sdi = st.s2[0];
endmodule

// ===== tw_host_model.sv
// Purpose: serial master model driving the three-wire port
// Assumes: sclk idles low; pins change on falling ref_clk edges
// Notes: released data lines toggle, so a stale bit never passes
module tw_host_model (
	// reference clock
	input wire logic ref_clk_i,
	// device data pins
	input wire logic dev_sdio_i,
	input wire logic dev_sdio_oe_n_i,
	input wire logic dev_sout_i,
	input wire logic dev_sout_oe_n_i,
	// host pins
	output logic sclk_o,
	output logic cs_n_o,
	output logic line_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic drv = 1'b1;
	logic hbit = 1'b0;
	logic junk = 1'b0;
	logic ol;
	// no pull resistor, so an undriven line shows a moving level
	always @(negedge ref_clk_i)
		junk <= ~junk;
	// wire level of both data pins from all parties
	assign line_o = !dev_sdio_oe_n_i ? dev_sdio_i : (drv ? hbit : junk);
	assign ol = !dev_sout_oe_n_i ? dev_sout_i : junk;
	// idle pins
	initial
	begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
	end
	// ----------------------------------------------------------------
	// one cycle; ord bit j is the bit order of byte j (0 = instruction)
	// ----------------------------------------------------------------
	task automatic frame(input logic [7:0] ins, input logic [4:0] ord, input logic bidir,
		input logic [31:0] wd, input int cut, output logic [31:0] rd);
		logic [39:0] tx;
		int nb;
		int j;
		int p;
		tx = {wd, ins};
		nb = (cut > 0) ? cut : 8 * (int'(ins[6:5]) + 2);
		rd = '0;
		// select low over the whole cycle
		cs_n_o = 1'b0;
		repeat (6) @(negedge ref_clk_i);
		// set while low, read late in the high phase
		for (int k = 0; k < nb; k++)
		begin
			j = k / 8;
			p = ord[j] ? k % 8 : 7 - k % 8;
			drv = !(ins[7] && j > 0);
			hbit = tx[8 * j + p];
			repeat (4) @(negedge ref_clk_i);
			sclk_o = 1'b1;
			repeat (4) @(negedge ref_clk_i);
			if (ins[7] && j > 0)
				rd[8 * j - 8 + p] = bidir ? line_o : ol;
			sclk_o = 1'b0;
		end
		repeat (4) @(negedge ref_clk_i);
		cs_n_o = 1'b1;
		drv = 1'b1;
		repeat (8) @(negedge ref_clk_i);
	endtask
endmodule

// ===== tw_port_tb_top.sv
// Purpose: self-checking bench of the three-wire port
// Assumes: register file is an array answered combinationally
// Notes: table rows first, then aborts and a second reset
module tw_port_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [7:0] ins;
		logic [4:0] ord;
		logic [1:0] cfg;
		logic [31:0] wd;
		logic [31:0] ex;
	} tw_row_t;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic sclk, cs_n, sdi, sdio, sdio_oe_n, sout, sout_oe_n, wr, bidir, lsb;
	logic [4:0] rd_addr, wr_addr;
	logic [7:0] wdata;
	logic [7:0] regs [32];
	int mismatches = 0;
	int samples_checked = 0;
	int wr_cnt = 0;
	int cs_hi = 0;
	// rows 8 and 11 change settings alone
	tw_row_t rows [13] = '{
		'{8'h73, 5'h00, 2'h0, 32'hd4c3b2a1, 32'h0}, '{8'hf3, 5'h00, 2'h0, 32'h0, 32'hd4c3b2a1},
		'{8'h20, 5'h00, 2'h0, 32'h7715, 32'h0}, '{8'hc1, 5'h00, 2'h0, 32'h0, 32'h771581},
		'{8'h20, 5'h04, 2'h1, 32'h6c40, 32'h0}, '{8'h81, 5'h1f, 2'h1, 32'h0, 32'h6c},
		'{8'h3e, 5'h1f, 2'h1, 32'h2211, 32'h0}, '{8'hde, 5'h1f, 2'h1, 32'h0, 32'h402211},
		'{8'h00, 5'h1f, 2'h3, 32'hc0, 32'h0}, '{8'h93, 5'h1f, 2'h3, 32'h0, 32'ha1},
		'{8'hf0, 5'h1f, 2'h3, 32'h0, 32'ha1b2c3d4}, '{8'h00, 5'h1f, 2'h0, 32'h0, 32'h0},
		'{8'h90, 5'h00, 2'h0, 32'h0, 32'hd4}};
	always #20 ref_clk = ~ref_clk;
	tw_port i_dut (.ref_clk_i(ref_clk), .resetn_i(resetn), .sclk_i(sclk), .chip_select_n_i(cs_n),
		.sdio_i(sdi), .sdio_o(sdio), .sdio_oe_n_o(sdio_oe_n), .serial_data_out_o(sout),
		.serial_data_out_oe_n_o(sout_oe_n), .reg_rd_addr_o(rd_addr), .reg_rdata_i(regs[rd_addr]),
		.reg_wr_o(wr), .reg_wr_addr_o(wr_addr), .reg_wdata_o(wdata), .bidir_mode_o(bidir),
		.lsb_first_o(lsb));
	tw_host_model i_host (.ref_clk_i(ref_clk), .dev_sdio_i(sdio), .dev_sdio_oe_n_i(sdio_oe_n),
		.dev_sout_i(sout), .dev_sout_oe_n_i(sout_oe_n), .sclk_o(sclk), .cs_n_o(cs_n), .line_o(sdi));
	// ----------------------------------------------------------------
	// reporting
	// ----------------------------------------------------------------
	task automatic err(input logic [31:0] got, input logic [31:0] exp);
		mismatches++;
		$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
			err(got, exp);
	endtask
	task automatic stop_test();
		$display("checks=%0d mismatches=%0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// register file and pin watchers
	always @(posedge ref_clk)
	begin
		cs_hi <= cs_n ? cs_hi + 1 : 0;
		if (wr)
		begin
			regs[wr_addr] <= wdata;
			wr_cnt <= wr_cnt + 1;
		end
		if (wr && cs_n)
			err(32'h1, 32'h0);
		if (cs_hi > 6 && !(sdio_oe_n && sout_oe_n))
			err({sdio_oe_n, sout_oe_n}, 32'h3);
		if (bidir && !sout_oe_n)
			err(sout_oe_n, 32'h1);
		if (!bidir && !sdio_oe_n)
			err(sdio_oe_n, 32'h1);
	end
	// hang guard, far beyond the real run
	initial
	begin
		#2ms;
		mismatches++;
		stop_test();
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		logic [31:0] rd;
		int w0;
		for (int k = 0; k < 32; k++)
			regs[k] = {3'h4, 5'(k)};
		repeat (6) @(negedge ref_clk);
		resetn = 1'b1;
		repeat (8) @(negedge ref_clk);
		chk({bidir, lsb, sdio_oe_n, sout_oe_n, wr}, 32'h6);
		// ordinary cycles: data, write count and port settings per row
		foreach (rows[r])
		begin
			w0 = wr_cnt;
			i_host.frame(rows[r].ins, rows[r].ord, rows[r].cfg[1], rows[r].wd, 0, rd);
			chk(rd, rows[r].ex);
			chk(wr_cnt - w0, rows[r].ins[7] ? 0 : rows[r].ins[6:5] + 1);
			chk({bidir, lsb}, rows[r].cfg);
			$display("row %0d done", r);
		end
		// select raised inside a data byte, then inside the instruction
		w0 = wr_cnt;
		i_host.frame(8'h05, 5'h00, 1'b0, 32'hff, 13, rd);
		i_host.frame(8'h00, 5'h00, 1'b0, 32'h0, 3, rd);
		chk(wr_cnt - w0, 0);
		i_host.frame(8'h85, 5'h00, 1'b0, 32'h0, 0, rd);
		chk(rd, 32'h85);
		$display("abort test done");
		// a second reset clears the port settings
		i_host.frame(8'h00, 5'h00, 1'b0, 32'hc0, 0, rd);
		chk({bidir, lsb}, 32'h3);
		resetn = 1'b0;
		repeat (4) @(negedge ref_clk);
		resetn = 1'b1;
		repeat (8) @(negedge ref_clk);
		chk({bidir, lsb}, 32'h0);
		$display("reset test done");
		stop_test();
	end
endmodule
